// ==== hdl/pmc_pkg.sv ====
package pmc_pkg;

  // register indices on the plain port (byte wide)
  localparam logic [3:0] pmc_off_power_control = 4'h0;
  localparam logic [3:0] pmc_off_clock_mode    = 4'h1;
  localparam logic [3:0] pmc_off_gate_enable   = 4'h2;
  localparam logic [3:0] pmc_off_wake_enable   = 4'h3;
  localparam logic [3:0] pmc_off_mode_select   = 4'h4;
  localparam logic [3:0] pmc_off_status        = 4'h5;
  localparam logic [3:0] pmc_off_supply_select = 4'h6;

  // power_control_reg fields
  localparam int pmc_idle_select_bit = 0;
  localparam int pmc_stop_select_bit = 1;
  // clock mode field
  localparam int pmc_low_power_gating_enable = 2;
  // mode select register fields
  localparam int pmc_suspend_bit = 0;
  localparam int pmc_sleep_bit   = 1;
  // supply select field: 0 battery, 1 buck_output
  localparam int pmc_supply_buck_bit = 0;

  // wake source bit positions
  localparam int pmc_wake_rtc      = 0;
  localparam int pmc_wake_port     = 1;
  localparam int pmc_wake_cmp0     = 2;
  localparam int pmc_wake_rst_pin  = 3;
  localparam int pmc_wake_pulse    = 4;
  localparam int pmc_wake_battery  = 5;
  localparam int pmc_wake_width    = 6;

  localparam logic [7:0] pmc_reset_byte      = 8'h00;
  localparam logic [5:0] pmc_wake_en_reset   = 6'h3f;
  localparam logic [3:0] pmc_gate_en_reset   = 4'h0;
  localparam logic [15:0] pmc_reset_vector   = 16'h0000;

  typedef enum logic [2:0] {
    pmc_normal,
    pmc_idle,
    pmc_stop,
    pmc_lp_idle,
    pmc_suspend,
    pmc_sleep
  } pmc_mode_t;

endpackage

// ==== hdl/pmc_power_mode_controller.sv ====
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        instr_done,
  input  wire logic        irq_pending,
  input  wire logic        int_reset,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_enabled,
  input  wire logic [5:0]  wake_event,
  output logic             cpu_halt,
  output logic             cpu_clock_gate,
  output logic             periph_run,
  output logic      [3:0]  periph_clock_en,
  output logic             resume_pulse,
  output logic             core_reset,
  output logic      [15:0] restart_vector,
  output logic             precision_osc_en,
  output logic             internal_osc_en,
  output logic             sys_clock_gate,
  output logic             core_supply_gate,
  output logic             rtc_osc_en,
  output logic             supply_from_buck,
  output logic      [2:0]  mode
);

  typedef struct packed {
    pmc_mode_t  mode;
    logic       idle_req;
    logic       stop_req;
    logic       suspend_req;
    logic       sleep_req;
    logic       gating_en;
    logic [3:0] gate_en;
    logic [5:0] wake_en;
    logic       buck;
    logic       resume;
    logic       rst_out;
    logic [7:0] rdata;
  } pmc_state_t;

  pmc_state_t st;
  pmc_state_t next_st;

  logic any_reset;
  logic wake_hit;

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_st = st;
    next_st.resume = 1'b0;
    next_st.rst_out = 1'b0;
    next_st.rdata = 8'h00;
    any_reset = int_reset | (watchdog_enabled & watchdog_timeout);
    wake_hit = |(wake_event & st.wake_en);

    if (wr) begin
      unique case (addr)
        pmc_off_power_control: begin
          // stop taken in preference so only one mode can follow
          next_st.stop_req = wdata[pmc_stop_select_bit];
          next_st.idle_req = wdata[pmc_idle_select_bit] &
                             ~wdata[pmc_stop_select_bit];
        end
        pmc_off_clock_mode:
          next_st.gating_en = wdata[pmc_low_power_gating_enable];
        pmc_off_gate_enable:
          next_st.gate_en = wdata[3:0];
        pmc_off_wake_enable:
          next_st.wake_en = wdata[5:0];
        pmc_off_mode_select: begin
          next_st.sleep_req = wdata[pmc_sleep_bit];
          next_st.suspend_req = wdata[pmc_suspend_bit] & ~wdata[pmc_sleep_bit];
        end
        pmc_off_supply_select:
          next_st.buck = wdata[pmc_supply_buck_bit];
        default: ;
      endcase
    end

    if (rd) begin
      unique case (addr)
        pmc_off_power_control:
          next_st.rdata = {6'h00, st.stop_req, st.idle_req};
        pmc_off_clock_mode:
          next_st.rdata = {5'h00, st.gating_en, 2'h0};
        pmc_off_gate_enable:   next_st.rdata = {4'h0, st.gate_en};
        pmc_off_wake_enable:   next_st.rdata = {2'h0, st.wake_en};
        pmc_off_mode_select:
          next_st.rdata = {6'h00, st.sleep_req, st.suspend_req};
        pmc_off_status:        next_st.rdata = {5'h00, st.mode};
        pmc_off_supply_select: next_st.rdata = {7'h00, st.buck};
        default:               next_st.rdata = 8'h00;
      endcase
    end

    unique case (st.mode)
      pmc_normal: begin
        // entry only once the setting instruction has retired
        if (instr_done) begin
          if (st.stop_req)
            next_st.mode = pmc_stop;
          else if (st.sleep_req)
            next_st.mode = pmc_sleep;
          else if (st.suspend_req)
            next_st.mode = pmc_suspend;
          else if (st.idle_req)
            next_st.mode = st.gating_en ? pmc_lp_idle : pmc_idle;
        end
      end
      pmc_idle, pmc_lp_idle: begin
        if (irq_pending) begin
          next_st.idle_req = 1'b0;
          next_st.resume = 1'b1;
          next_st.mode = pmc_normal;
        end
      end
      pmc_stop: ; // interrupts ignored here
      pmc_suspend, pmc_sleep: begin
        // fast resume: no reset, continue at next instruction
        if (wake_hit) begin
          next_st.suspend_req = 1'b0;
          next_st.sleep_req = 1'b0;
          next_st.resume = 1'b1;
          next_st.mode = pmc_normal;
        end
      end
      default: next_st.mode = pmc_normal;
    endcase

    // any reset restarts the core from the vector, from every mode
    if (any_reset) begin
      next_st.mode = pmc_normal;
      next_st.idle_req = 1'b0;
      next_st.stop_req = 1'b0;
      next_st.suspend_req = 1'b0;
      next_st.sleep_req = 1'b0;
      next_st.resume = 1'b0;
      next_st.rst_out = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; only mode-control state, the core keeps its own data

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{mode: pmc_normal, idle_req: 1'b0, stop_req: 1'b0,
              suspend_req: 1'b0, sleep_req: 1'b0, gating_en: 1'b0,
              gate_en: pmc_gate_en_reset, wake_en: pmc_wake_en_reset,
              buck: 1'b0, resume: 1'b0, rst_out: 1'b0,
              rdata: pmc_reset_byte};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs decoded from the state register, restart_vector and rtc_osc_en constant; the other oscillator controls and core_supply_gate
  // from its mode field alone, supply_from_buck from its buck field

  always_comb begin
    mode = st.mode;
    rdata = st.rdata;
    resume_pulse = st.resume;
    core_reset = st.rst_out;
    restart_vector = pmc_reset_vector;
    supply_from_buck = st.buck;
    cpu_halt = (st.mode != pmc_normal);
    cpu_clock_gate = (st.mode == pmc_lp_idle);
    periph_run = (st.mode == pmc_normal) || (st.mode == pmc_idle) ||
                 (st.mode == pmc_lp_idle);
    // low power idle clocks only the enabled peripheral groups
    periph_clock_en = (st.mode == pmc_lp_idle) ? st.gate_en :
                      (periph_run ? 4'hf : 4'h0);
    precision_osc_en = (st.mode != pmc_stop) && (st.mode != pmc_suspend) &&
                       (st.mode != pmc_sleep);
    internal_osc_en = (st.mode != pmc_suspend) &&
                      (st.mode != pmc_sleep);
    sys_clock_gate = (st.mode == pmc_suspend) ||
                     (st.mode == pmc_sleep);
    core_supply_gate = (st.mode == pmc_sleep);
    rtc_osc_en = 1'b1;
  end

endmodule

// ==== testbench/pmc_power_mode_controller_asserts.sv ====
`timescale 1ns/1ns
module pmc_power_mode_controller_asserts
  import pmc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [2:0] mode,
  input wire logic       cpu_halt,
  input wire logic       irq_pending,
  input wire logic       int_reset,
  input wire logic       watchdog_timeout,
  input wire logic       watchdog_enabled,
  input wire logic       resume_pulse,
  input wire logic       core_reset,
  input wire logic       precision_osc_en,
  input wire logic       internal_osc_en,
  input wire logic       sys_clock_gate,
  input wire logic       core_supply_gate,
  input wire logic       rtc_osc_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rq;
  logic idl;
  assign rq = int_reset | (watchdog_timeout & watchdog_enabled);
  assign idl = (mode == 3'h1) || (mode == 3'h3);
  //////////////////////////////////////////////////////////////////////
  sequence s_reset_exit;
    (mode == 3'h0) && core_reset;
  endsequence
  sequence s_resume;
    (mode == 3'h0) && resume_pulse ##1 !resume_pulse;
  endsequence
  property p_halt; cpu_halt == (mode != 3'h0); endproperty
  property p_legal; mode <= 3'h5; endproperty
  property p_reset; rq |=> s_reset_exit; endproperty
  property p_stop_hold; (mode == 3'h2) && !rq |=> mode == 3'h2; endproperty
  property p_idle_hold; idl && !irq_pending && !rq |=> $stable(mode);
  endproperty
  property p_idle_exit; idl && irq_pending && !rq |=> s_resume; endproperty
  property p_stop_osc; mode == 3'h2 |-> !precision_osc_en; endproperty
  property p_susp; mode == 3'h4 |-> sys_clock_gate && !internal_osc_en;
  endproperty
  property p_sleep; mode == 3'h5 |-> core_supply_gate && rtc_osc_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  a_legal: assert property (p_legal) else $error("bad mode");
  a_reset: assert property (p_reset) else $error("no reset");
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop left");
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle left");
  a_idle_exit: assert property (p_idle_exit)
    else $error("no resume");
  a_stop_osc: assert property (p_stop_osc) else $error("osc on");
  a_susp: assert property (p_susp) else $error("clock on");
  a_sleep: assert property (p_sleep) else $error("supply on");
endmodule
bind pmc_power_mode_controller pmc_power_mode_controller_asserts u_chk (
  .clock, .rst, .mode, .cpu_halt, .irq_pending, .int_reset,
  .watchdog_timeout, .watchdog_enabled, .resume_pulse, .core_reset,
  .precision_osc_en, .internal_osc_en, .sys_clock_gate,
  .core_supply_gate, .rtc_osc_en);

// ==== testbench/pmc_core_model.sv ====
`timescale 1ns/1ns
module pmc_core_model
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic cpu_halt,
  input  wire logic slow,
  output logic      instr_done
);
  // slow core retires every other cycle, a halted one never
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= !cpu_halt && (!slow || !instr_done);
    end
  end
endmodule

// ==== testbench/pmc_power_mode_controller_tb_top.sv ====
`timescale 1ns/1ns
module pmc_power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic irq_pending = 1'b0, int_reset = 1'b0, watchdog_timeout = 1'b0;
  logic watchdog_enabled = 1'b0, cpu_halt, instr_done, supply_from_buck;
  logic cpu_clock_gate, periph_run;
  logic [3:0] addr = 4'h0, periph_clock_en;
  logic [7:0] wdata = 8'h00, rdata, lfsr = 8'h06;
  logic [5:0] wake_event = 6'h00;
  logic [15:0] restart_vector;
  logic [2:0] mode;
  int failures = 0, check_count = 0, cyc = 0;
  always #50 clock = ~clock;
  pmc_core_model u_core (.clock, .rst, .cpu_halt, .slow, .instr_done);
  pmc_power_mode_controller u_dut (.clock, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .instr_done, .irq_pending, .int_reset, .watchdog_timeout,
    .watchdog_enabled, .wake_event, .cpu_halt, .cpu_clock_gate,
    .periph_run, .periph_clock_en, .resume_pulse(), .core_reset(),
    .restart_vector, .precision_osc_en(), .internal_osc_en(),
    .sys_clock_gate(), .core_supply_gate(), .rtc_osc_en(),
    .supply_from_buck, .mode);
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(logic [3:0] a, logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(e));
  endtask
  // bounded wait; the core model may stall entry
  task automatic wait_mode(logic [2:0] e);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      if (mode === e) break;
    end
    chk(16'(mode), 16'(e));
  endtask
  task automatic hit(logic [2:0] m);
    @(posedge clock);
    {watchdog_timeout, int_reset, irq_pending} <= m;
    @(posedge clock);
    {watchdog_timeout, int_reset, irq_pending} <= 3'h0;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test;
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rchk(pmc_off_status, 8'h00);
    rchk(pmc_off_wake_enable, 8'h3f);
    rchk(4'h7, 8'h00);
    $display("registers done");
    @(posedge clock);
    slow <= 1'b1;
    wreg(pmc_off_power_control, 8'h01);
    wait_mode(pmc_idle);
    chk(16'(periph_clock_en), 16'h000f);
    chk(16'(periph_run), 16'h0001);
    chk(16'(cpu_clock_gate), 16'h0000);
    rchk(pmc_off_status, 8'h01);
    hit(3'b001);
    wait_mode(pmc_normal);
    rchk(pmc_off_power_control, 8'h00);
    lfsr = lfsr_next(lfsr);
    wreg(pmc_off_gate_enable, lfsr);
    wreg(pmc_off_clock_mode, 8'h04);
    wreg(pmc_off_power_control, 8'h01);
    wait_mode(pmc_lp_idle);
    chk(16'(periph_clock_en), 16'(lfsr[3:0]));
    chk(16'(cpu_clock_gate), 16'h0001);
    hit(3'b001);
    wait_mode(pmc_normal);
    wreg(pmc_off_clock_mode, 8'h00);
    $display("idle done");
    wreg(pmc_off_power_control, 8'h03);
    wait_mode(pmc_stop);
    chk(16'(periph_run), 16'h0000);
    hit(3'b001);
    wait_mode(pmc_stop);
    hit(3'b010);
    wait_mode(pmc_normal);
    chk(restart_vector, 16'h0000);
    wreg(pmc_off_power_control, 8'h01);
    wait_mode(pmc_idle);
    hit(3'b100);
    wait_mode(pmc_idle);
    @(posedge clock);
    watchdog_enabled <= 1'b1;
    hit(3'b100);
    wait_mode(pmc_normal);
    @(posedge clock);
    watchdog_enabled <= 1'b0;
    $display("stop done");
    for (int i = 0; i < 6; i++) begin
      wreg(pmc_off_mode_select, i[0] ? 8'h02 : 8'h01);
      wait_mode(i[0] ? pmc_sleep : pmc_suspend);
      @(posedge clock);
      wake_event <= 6'(1 << i);
      @(posedge clock);
      wake_event <= 6'h00;
      wait_mode(pmc_normal);
    end
    wreg(pmc_off_supply_select, 8'h01);
    #1 chk(16'(supply_from_buck), 16'h0001);
    $display("suspend done");
    end_of_test;
  end
endmodule
